// File: hdl/flash_spc_pkg.sv
// constants of the flash self-program control block
package flash_spc_pkg;

  localparam int SEL_W = 4;
  localparam logic [3:0] REG_FLASH_CONTROL_MAIN = 4'h0;
  localparam logic [3:0] REG_CHIP_RESET_KEY = 4'h1;
  localparam logic [3:0] REG_BUFFER_CONTROL = 4'h2;
  localparam logic [3:0] REG_ADDRESS_LOW_BYTE = 4'h3;
  localparam logic [3:0] REG_ADDRESS_HIGH_BYTE = 4'h4;
  localparam logic [3:0] REG_WORD0_LOW_BYTE = 4'h5;
  localparam logic [3:0] REG_WORD0_HIGH_BYTE = 4'h6;
  localparam logic [3:0] REG_WORD1_LOW_BYTE = 4'h7;
  localparam logic [3:0] REG_WORD1_HIGH_BYTE = 4'h8;
  localparam logic [3:0] REG_WORD2_LOW_BYTE = 4'h9;
  localparam logic [3:0] REG_WORD2_HIGH_BYTE = 4'hA;
  localparam logic [3:0] REG_WORD3_LOW_BYTE = 4'hB;
  localparam logic [3:0] REG_WORD3_HIGH_BYTE = 4'hC;
  localparam int DATA_REGS = 8;

  localparam int BIT_UNLOCK_STATUS = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_UNLOCK_TRIGGER = 3;
  localparam int BIT_PROGRAM_START = 2;
  localparam int BIT_READ_PERMIT = 1;
  localparam int BIT_READ_START = 0;
  localparam int BIT_BUFFER_RESERVED = 1;
  localparam int BIT_BUFFER_CLEAR_START = 0;

  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_PAGE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;

  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] CHIP_RESET_KEY_VALUE = 8'h55;

  localparam int ADDR_W = 14;
  localparam int PAGE_OFS_W = 5;
  localparam logic [4:0] PAGE_LAST_OFS = 5'h1F;
  localparam logic [13:0] ADDR_RESET = 14'h0000;

  // unlock sequence: register and byte, in write order
  localparam int UNLOCK_STEPS = 6;
  localparam logic [2:0] STEP_DONE = 3'h6;
  localparam logic [2:0] STEP_FAIL = 3'h7;
  localparam logic [47:0] UNLOCK_PATTERN = 48'h000DC304_0940;
  localparam logic [23:0] UNLOCK_ORDER = 24'h79B8AC;

  localparam int CLK_PERIOD_NS = 100;
  localparam int UNLOCK_TIME_NS = 10000;
  localparam int UNLOCK_CYCLES = UNLOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int BUF_CLEAR_CYCLES = 32;

endpackage

// File: hdl/pulse_timer.sv
// down counter that runs a fixed number of cycles and pulses at the end
module pulse_timer #(
  parameter int COUNT = 4
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic expire_o
);

  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LOAD = CW'(COUNT);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start_i) begin
      cnt_d = LOAD;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - ONE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_o = (cnt_q != '0);
  assign expire_o = (cnt_q == ONE) && !start_i;

endmodule

// File: hdl/unlock_pattern_check.sv
// tracks the unlock byte sequence written into data words one to three
module unlock_pattern_check (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic arm_i,
  input wire logic wr_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] wdata_i,
  output logic match_o
);

  logic [2:0] step_q;
  logic [2:0] step_d;
  logic [7:0] exp_byte;
  logic [3:0] exp_sel;
  logic watched;

  always_comb begin
    exp_byte = 8'h00;
    exp_sel = 4'h0;
    if (step_q < flash_spc_pkg::STEP_DONE) begin
      exp_byte = flash_spc_pkg::UNLOCK_PATTERN[8*(5-int'(step_q)) +: 8];
      exp_sel = flash_spc_pkg::UNLOCK_ORDER[4*(5-int'(step_q)) +: 4];
    end
    watched = (sel_i >= flash_spc_pkg::REG_WORD1_LOW_BYTE)
      && (sel_i <= flash_spc_pkg::REG_WORD3_HIGH_BYTE);
    step_d = step_q;
    if (arm_i) begin
      step_d = 3'h0;
    end else if (wr_i && watched && step_q < flash_spc_pkg::STEP_DONE) begin
      step_d = (sel_i == exp_sel && wdata_i == exp_byte) ? step_q + 3'h1
        : flash_spc_pkg::STEP_FAIL;
    end else if (wr_i && watched) begin
      step_d = flash_spc_pkg::STEP_FAIL;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      step_q <= flash_spc_pkg::STEP_FAIL;
    end else begin
      step_q <= step_d;
    end
  end

  assign match_o = (step_q == flash_spc_pkg::STEP_DONE);

endmodule

// File: hdl/flash_self_program_control.sv
// flash self-program control: registers, unlock, operation sequencing
// Behaviour
// - mode 000 write, 001 erase, 011 read, 110 unlock
// - unlock trigger starts timer, hardware clears at expiry
// - program start launches write (mode 000) or erase (mode 001), cleared on completion
// - reads happen only while read permit set
// - read start begins read, cleared when done
// - processor halted while a write, erase or read runs (not during buffer clear)
// - writing 55H to key resets whole chip
// - buffer control bits 7..2 read zero; bit1 stores the written value
// - buffer clear bit self-clears after clearing finishes
// - 14-bit word address split low/high, top bits zero
// - word0 low write only stores the byte
// - word0 high write loads buffer only while unlocked, increments address
// - words one to three held as byte pairs
// - exact six-byte ordered pattern unlocks erase/write
// - address stops at page offset 31
// - unlock status set by hardware only; software clears
// - write completion clears the write buffer
module flash_self_program_control (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic [3:0] reg_sel_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic arr_done_i,
  input wire logic [15:0] arr_rdata_i,
  output logic arr_program_o,
  output logic arr_erase_o,
  output logic arr_read_o,
  output logic arr_buf_load_o,
  output logic arr_buf_clear_o,
  output logic [13:0] arr_addr_o,
  output logic [15:0] arr_buf_data_o,
  output logic cpu_halt_o,
  output logic chip_reset_o
);

  typedef enum logic [2:0] {OP_IDLE, OP_PROGRAM, OP_ERASE, OP_READ, OP_BUF_CLEAR} op_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // state
  op_state_t op_q, op_d;
  logic unlock_q, unlock_d;
  logic [2:0] mode_q, mode_d;
  logic trig_q, trig_d;
  logic prog_q, prog_d;
  logic permit_q, permit_d;
  logic rdstart_q, rdstart_d;
  logic [7:0] key_q, key_d;
  logic bres_q, bres_d;
  logic clr_q, clr_d;
  logic [13:0] addr_q, addr_d;
  logic [7:0] data_q [flash_spc_pkg::DATA_REGS];
  logic [7:0] data_d [flash_spc_pkg::DATA_REGS];
  logic [7:0] rdata_q, rdata_d;
  logic aprog_q, aprog_d, aerase_q, aerase_d, aread_q, aread_d;
  logic load_q, load_d, bclr_q, bclr_d;
  logic [15:0] bdata_q, bdata_d;
  logic halt_q, halt_d;
  logic rst_out_q, rst_out_d;
  logic bump_q, bump_d;

  logic wr_ctl, wr_buf, wr_key, wr_d0h;
  logic trig_start, unlock_expire, unlock_busy, match;
  logic clr_start, clr_expire, clr_busy;

  assign wr_ctl = reg_wr_i && reg_sel_i == flash_spc_pkg::REG_FLASH_CONTROL_MAIN;
  assign wr_buf = reg_wr_i && reg_sel_i == flash_spc_pkg::REG_BUFFER_CONTROL;
  assign wr_key = reg_wr_i && reg_sel_i == flash_spc_pkg::REG_CHIP_RESET_KEY;
  assign wr_d0h = reg_wr_i && reg_sel_i == flash_spc_pkg::REG_WORD0_HIGH_BYTE;
  assign trig_start = wr_ctl && reg_wdata_i[flash_spc_pkg::BIT_UNLOCK_TRIGGER] && !trig_q;
  assign clr_start = wr_buf && reg_wdata_i[flash_spc_pkg::BIT_BUFFER_CLEAR_START]
    && !clr_q && op_q == OP_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  pulse_timer #(.COUNT(flash_spc_pkg::UNLOCK_CYCLES)) u_unlock_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(trig_start),
    .busy_o(unlock_busy),
    .expire_o(unlock_expire)
  );

  pulse_timer #(.COUNT(flash_spc_pkg::BUF_CLEAR_CYCLES)) u_clear_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(clr_start),
    .busy_o(clr_busy),
    .expire_o(clr_expire)
  );

  unlock_pattern_check u_pattern (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .arm_i(trig_start),
    .wr_i(reg_wr_i && unlock_busy),
    .sel_i(reg_sel_i),
    .wdata_i(reg_wdata_i),
    .match_o(match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    op_d = op_q;
    unlock_d = unlock_q;
    mode_d = mode_q;
    trig_d = trig_q;
    prog_d = prog_q;
    permit_d = permit_q;
    rdstart_d = rdstart_q;
    key_d = key_q;
    bres_d = bres_q;
    clr_d = clr_q;
    addr_d = addr_q;
    data_d = data_q;
    aprog_d = 1'b0;
    aerase_d = 1'b0;
    aread_d = 1'b0;
    load_d = 1'b0;
    bclr_d = 1'b0;
    bdata_d = bdata_q;
    rst_out_d = 1'b0;
    bump_d = 1'b0;

    if (wr_ctl) begin
      mode_d = reg_wdata_i[flash_spc_pkg::BIT_MODE_HI:flash_spc_pkg::BIT_MODE_LO];
      permit_d = reg_wdata_i[flash_spc_pkg::BIT_READ_PERMIT];
      if (trig_start) begin
        trig_d = 1'b1;
      end
      if (!reg_wdata_i[flash_spc_pkg::BIT_UNLOCK_STATUS]) begin
        unlock_d = 1'b0;
      end
      if (op_q == OP_IDLE && reg_wdata_i[flash_spc_pkg::BIT_PROGRAM_START]) begin
        prog_d = 1'b1;
      end
      if (op_q == OP_IDLE && reg_wdata_i[flash_spc_pkg::BIT_READ_START]) begin
        rdstart_d = 1'b1;
      end
    end
    if (unlock_expire) begin
      trig_d = 1'b0;
      if (match && mode_q == flash_spc_pkg::MODE_UNLOCK) begin
        unlock_d = 1'b1;
      end
    end

    if (wr_key) begin
      key_d = reg_wdata_i;
      rst_out_d = (reg_wdata_i == flash_spc_pkg::CHIP_RESET_KEY_VALUE);
    end
    if (wr_buf) begin
      bres_d = reg_wdata_i[flash_spc_pkg::BIT_BUFFER_RESERVED];
    end
    if (clr_start) begin
      clr_d = 1'b1;
      bclr_d = 1'b1;
      op_d = OP_BUF_CLEAR;
    end

    for (int i = 0; i < flash_spc_pkg::DATA_REGS; i++) begin
      if (reg_wr_i && reg_sel_i == 4'(int'(flash_spc_pkg::REG_WORD0_LOW_BYTE) + i)) begin
        data_d[i] = reg_wdata_i;
      end
    end
    if (bump_q) begin
      addr_d = addr_q + 14'h0001;
    end
    if (reg_wr_i && reg_sel_i == flash_spc_pkg::REG_ADDRESS_LOW_BYTE) begin
      addr_d[7:0] = reg_wdata_i;
    end
    if (reg_wr_i && reg_sel_i == flash_spc_pkg::REG_ADDRESS_HIGH_BYTE) begin
      addr_d[13:8] = reg_wdata_i[5:0];
    end
    if (wr_d0h) begin
      load_d = unlock_q;
      bdata_d = {reg_wdata_i, data_q[0]};
      if (addr_q[flash_spc_pkg::PAGE_OFS_W-1:0] != flash_spc_pkg::PAGE_LAST_OFS) begin
        bump_d = 1'b1;
      end
    end

    unique case (op_q)
      OP_IDLE: begin
        if (prog_q) begin
          if (unlock_q && mode_q == flash_spc_pkg::MODE_WRITE) begin
            aprog_d = 1'b1;
            op_d = OP_PROGRAM;
          end else if (unlock_q && mode_q == flash_spc_pkg::MODE_PAGE_ERASE) begin
            aerase_d = 1'b1;
            op_d = OP_ERASE;
          end else begin
            prog_d = wr_ctl && reg_wdata_i[flash_spc_pkg::BIT_PROGRAM_START];
          end
        end else if (rdstart_q) begin
          if (permit_q && mode_q == flash_spc_pkg::MODE_READ) begin
            aread_d = 1'b1;
            op_d = OP_READ;
          end else begin
            rdstart_d = wr_ctl && reg_wdata_i[flash_spc_pkg::BIT_READ_START];
          end
        end
      end
      OP_PROGRAM: begin
        if (arr_done_i) begin
          prog_d = 1'b0;
          bclr_d = 1'b1;
          op_d = OP_IDLE;
        end
      end
      OP_ERASE: begin
        if (arr_done_i) begin
          prog_d = 1'b0;
          op_d = OP_IDLE;
        end
      end
      OP_READ: begin
        if (arr_done_i) begin
          rdstart_d = 1'b0;
          data_d[0] = arr_rdata_i[7:0];
          data_d[1] = arr_rdata_i[15:8];
          op_d = OP_IDLE;
        end
      end
      OP_BUF_CLEAR: begin
        if (clr_expire) begin
          clr_d = 1'b0;
          op_d = OP_IDLE;
        end
      end
    endcase

    halt_d = (op_d == OP_PROGRAM) || (op_d == OP_ERASE) || (op_d == OP_READ);

    unique case (reg_sel_i)
      flash_spc_pkg::REG_FLASH_CONTROL_MAIN:
        rdata_d = {unlock_q, mode_q, trig_q, prog_q, permit_q, rdstart_q};
      flash_spc_pkg::REG_CHIP_RESET_KEY: rdata_d = key_q;
      flash_spc_pkg::REG_BUFFER_CONTROL: rdata_d = {6'h00, bres_q, clr_q};
      flash_spc_pkg::REG_ADDRESS_LOW_BYTE: rdata_d = addr_q[7:0];
      flash_spc_pkg::REG_ADDRESS_HIGH_BYTE: rdata_d = {2'h0, addr_q[13:8]};
      default: begin
        rdata_d = 8'h00;
        if (reg_sel_i >= flash_spc_pkg::REG_WORD0_LOW_BYTE
            && reg_sel_i <= flash_spc_pkg::REG_WORD3_HIGH_BYTE) begin
          rdata_d = data_q[3'(reg_sel_i - flash_spc_pkg::REG_WORD0_LOW_BYTE)];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      op_q <= OP_IDLE;
      unlock_q <= 1'b0;
      mode_q <= 3'h0;
      trig_q <= 1'b0;
      prog_q <= 1'b0;
      permit_q <= 1'b0;
      rdstart_q <= 1'b0;
      key_q <= flash_spc_pkg::BYTE_RESET;
      bres_q <= 1'b0;
      clr_q <= 1'b0;
      addr_q <= flash_spc_pkg::ADDR_RESET;
      for (int i = 0; i < flash_spc_pkg::DATA_REGS; i++) begin
        data_q[i] <= flash_spc_pkg::BYTE_RESET;
      end
      rdata_q <= 8'h00;
      aprog_q <= 1'b0;
      aerase_q <= 1'b0;
      aread_q <= 1'b0;
      load_q <= 1'b0;
      bclr_q <= 1'b0;
      bdata_q <= 16'h0000;
      halt_q <= 1'b0;
      rst_out_q <= 1'b0;
      bump_q <= 1'b0;
    end else begin
      op_q <= op_d;
      unlock_q <= unlock_d;
      mode_q <= mode_d;
      trig_q <= trig_d;
      prog_q <= prog_d;
      permit_q <= permit_d;
      rdstart_q <= rdstart_d;
      key_q <= key_d;
      bres_q <= bres_d;
      clr_q <= clr_d;
      addr_q <= addr_d;
      data_q <= data_d;
      rdata_q <= rdata_d;
      aprog_q <= aprog_d;
      aerase_q <= aerase_d;
      aread_q <= aread_d;
      load_q <= load_d;
      bclr_q <= bclr_d;
      bdata_q <= bdata_d;
      halt_q <= halt_d;
      rst_out_q <= rst_out_d;
      bump_q <= bump_d;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign arr_program_o = aprog_q;
  assign arr_erase_o = aerase_q;
  assign arr_read_o = aread_q;
  assign arr_buf_load_o = load_q;
  assign arr_buf_clear_o = bclr_q;
  assign arr_addr_o = addr_q;
  assign arr_buf_data_o = bdata_q;
  assign cpu_halt_o = halt_q;
  assign chip_reset_o = rst_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  localparam int CLR_LO = 32;
  localparam int CLR_HI = 33;

  sequence s_prog_launch;
    (op_q == OP_IDLE) && prog_q && unlock_q && mode_q == flash_spc_pkg::MODE_WRITE;
  endsequence
  sequence s_prog_finish;
    (op_q == OP_PROGRAM) && arr_done_i;
  endsequence

  a_mode_write_launch: assert property (s_prog_launch |=> arr_program_o && cpu_halt_o)
    else $error("write mode did not launch program");
  a_trigger_clear: assert property (unlock_expire |=> !trig_q)
    else $error("unlock trigger not cleared at expiry");
  a_prog_complete: assert property (s_prog_finish |=> !prog_q && arr_buf_clear_o)
    else $error("program start or buffer clear wrong at completion");
  a_read_inhibit: assert property (arr_read_o |-> $past(permit_q))
    else $error("read issued without permit");
  a_read_done: assert property ((op_q == OP_READ) && arr_done_i |=> !rdstart_q)
    else $error("read start not cleared");
  a_halt_busy: assert property (cpu_halt_o == (op_q inside {OP_PROGRAM, OP_ERASE, OP_READ}))
    else $error("halt does not follow operation");
  a_chip_reset: assert property (wr_key && reg_wdata_i == 8'h55 |=> chip_reset_o)
    else $error("key write gave no chip reset");
  a_buf_ctl_zero: assert property (reg_sel_i == flash_spc_pkg::REG_BUFFER_CONTROL
      |=> reg_rdata_o[7:2] == 6'h00)
    else $error("buffer control upper bits not zero");
  a_buf_clear_time: assert property (clr_start |=> clr_q ##[CLR_LO:CLR_HI] !clr_q)
    else $error("buffer clear bit timing wrong");
  a_low_no_load: assert property (reg_wr_i && reg_sel_i == flash_spc_pkg::REG_WORD0_LOW_BYTE
      && !wr_d0h |=> !arr_buf_load_o)
    else $error("low byte write loaded buffer");
  a_addr_inc: assert property (wr_d0h && addr_q[4:0] != 5'h1F
      |=> ##1 arr_addr_o == $past(addr_q, 2) + 14'h0001)
    else $error("address did not increment");
  a_addr_stop: assert property (wr_d0h && addr_q[4:0] == 5'h1F
      |=> ##1 arr_addr_o == $past(addr_q, 2))
    else $error("address passed page end");
  a_unlock_hw_only: assert property ($rose(unlock_q) |-> $past(unlock_expire && match))
    else $error("unlock set without pattern");
  a_locked_no_modify: assert property (arr_program_o || arr_erase_o |-> $past(unlock_q))
    else $error("flash modified while locked");

endmodule

// File: tb/flash_array_model.sv
// behavioural flash array: timed program, erase and read with done pulse
module flash_array_model #(
  parameter int LAT = 6
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic program_i,
  input wire logic erase_i,
  input wire logic read_i,
  input wire logic [13:0] addr_i,
  output logic done_o,
  output logic [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  logic rd_q;
  ////////////////////////////////////////////////////////////////////////////
  // busy count, then one done pulse; read word only valid with done
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (sys_rst_i) begin
      cnt <= 0;
      rd_q <= 1'b0;
      rdata_o <= 16'h0000;
    end else if (program_i || erase_i || read_i) begin
      cnt <= LAT;
      rd_q <= read_i;
    end else if (cnt == 1) begin
      cnt <= 0;
      done_o <= 1'b1;
      if (rd_q) begin
        rdata_o <= {2'h0, addr_i} ^ 16'h5A3C;
      end
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: tb/flash_self_program_control_tb_top.sv
// register-level testbench of the flash self-program control block
module flash_self_program_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LAT = 6;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic [3:0] reg_sel_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic done, prog, ers, rdo, bload, bclr, halt, crst;
  logic [13:0] addr, l_addr;
  logic [15:0] rdata, bdata, l_data;
  int fails = 0;
  int comparisons = 0;
  int n_prog = 0, n_ers = 0, n_rd = 0, n_load = 0, n_clr = 0, n_rst = 0, n_halt = 0;
  logic [7:0] useq [6] = '{8'h7, 8'h9, 8'hB, 8'h8, 8'hA, 8'hC};
  logic [7:0] upat [6] = '{8'h00, 8'h0D, 8'hC3, 8'h04, 8'h09, 8'h40};

  flash_self_program_control dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .arr_done_i(done), .arr_rdata_i(rdata),
    .arr_program_o(prog), .arr_erase_o(ers), .arr_read_o(rdo), .arr_buf_load_o(bload),
    .arr_buf_clear_o(bclr), .arr_addr_o(addr), .arr_buf_data_o(bdata),
    .cpu_halt_o(halt), .chip_reset_o(crst));
  flash_array_model #(.LAT(LAT)) array_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .program_i(prog), .erase_i(ers), .read_i(rdo), .addr_i(addr), .done_o(done),
    .rdata_o(rdata));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #50 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (!sys_rst_i) begin
      n_prog += int'(prog === 1'b1);
      n_ers += int'(ers === 1'b1);
      n_rd += int'(rdo === 1'b1);
      n_clr += int'(bclr === 1'b1);
      n_rst += int'(crst === 1'b1);
      n_halt += int'(halt === 1'b1);
      if (bload === 1'b1) begin
        n_load++;
        l_addr = addr;
        l_data = bdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(negedge clock_i);
    reg_sel_i = s;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
  endtask

  task automatic rc(input logic [3:0] s, input logic [7:0] e);
    @(negedge clock_i);
    reg_sel_i = s;
    @(negedge clock_i);
    chk({8'h00, reg_rdata_o}, {8'h00, e});
  endtask

  task automatic wait_idle;
    int i;
    i = 0;
    repeat (3) @(negedge clock_i);
    while (halt !== 1'b0 && i < 100) begin
      @(negedge clock_i);
      i++;
    end
    chk({15'h0, halt}, 16'h0000);
    repeat (2) @(negedge clock_i);
  endtask

  // good: ordered pattern; otherwise first two steps swapped
  task automatic unlock(input bit good);
    int k;
    wr(4'h0, 8'h68);
    for (int j = 0; j < 6; j++) begin
      k = (!good && j < 2) ? 1 - j : j;
      wr(useq[k][3:0], upat[k]);
    end
    rc(4'h0, 8'h68);
    repeat (110) @(negedge clock_i);
    rc(4'h0, good ? 8'hE0 : 8'h60);
  endtask

  task automatic op_loop(input logic [7:0] top);
    int p, e, c, h;
    for (int m = 0; m < 8; m++) begin
      p = n_prog;
      e = n_ers;
      c = n_clr;
      h = n_halt;
      wr(4'h0, top | 8'(m << 4) | 8'h04);
      wait_idle;
      chk(16'(n_prog - p), 16'(top[7] && m == 0));
      chk(16'(n_ers - e), 16'(top[7] && m == 1));
      chk(16'(n_halt - h >= LAT), 16'(top[7] && m < 2));
      if (m == 0) begin
        chk(16'(n_clr - c), 16'(top[7]));
      end
      rc(4'h0, top | 8'(m << 4));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int p;
    repeat (20) @(negedge clock_i);
    sys_rst_i = 1'b0;
    for (int s = 0; s < 16; s++) begin
      rc(4'(s), 8'h00);
    end
    wr(4'hE, 8'hFF);
    rc(4'hE, 8'h00);
    p = n_rst;
    wr(4'h1, 8'h54);
    rc(4'h1, 8'h54);
    chk(16'(n_rst - p), 16'h0000);
    wr(4'h1, 8'h55);
    @(negedge clock_i);
    chk(16'(n_rst - p), 16'h0001);
    wr(4'h2, 8'hFC);
    rc(4'h2, 8'h00);
    p = n_clr;
    wr(4'h2, 8'h01);
    rc(4'h2, 8'h01);
    chk(16'(n_clr - p), 16'h0001);
    repeat (40) @(negedge clock_i);
    rc(4'h2, 8'h00);
    wr(4'h4, 8'hFF);
    rc(4'h4, 8'h3F);
    wr(4'h3, 8'hA5);
    rc(4'h3, 8'hA5);
    wr(4'h0, 8'h80);
    rc(4'h0, 8'h00);
    wr(4'h4, 8'h01);
    wr(4'h3, 8'h25);
    p = n_rd;
    wr(4'h0, 8'h31);
    wait_idle;
    chk(16'(n_rd - p), 16'h0000);
    wr(4'h0, 8'h32);
    wr(4'h0, 8'h33);
    wait_idle;
    chk(16'(n_rd - p), 16'h0001);
    rc(4'h0, 8'h32);
    rc(4'h5, 8'h3C ^ 8'h25);
    rc(4'h6, 8'h5A ^ 8'h01);
    op_loop(8'h00);
    unlock(1'b0);
    unlock(1'b1);
    wr(4'h3, 8'h1E);
    wr(4'h4, 8'h00);
    p = n_load;
    wr(4'h5, 8'hAB);
    chk(16'(n_load - p), 16'h0000);
    wr(4'h6, 8'hCD);
    @(negedge clock_i);
    chk(16'(n_load - p), 16'h0001);
    chk(l_data, 16'hCDAB);
    chk({2'h0, l_addr}, 16'h001E);
    rc(4'h3, 8'h1F);
    wr(4'h5, 8'h12);
    wr(4'h6, 8'h34);
    rc(4'h3, 8'h1F);
    rc(4'h4, 8'h00);
    op_loop(8'h80);
    wr(4'h0, 8'h00);
    p = n_prog;
    wr(4'h0, 8'h04);
    wait_idle;
    chk(16'(n_prog - p), 16'h0000);
    rc(4'h0, 8'h00);
    summarize;
  end

  initial begin
    #(5000 * 100);
    fails++;
    summarize;
  end
endmodule
